// ==== core/wfl_pkg.sv ====
// constants for the wake-frame filter and link-status block
// assumes a 100 MHz core clock and word-aligned 32-bit register access
package wfl_pkg;
  // register indices; byte address is four times the index
  localparam logic [7:0] IDX_PHY_CTRL = 8'h22;
  localparam logic [7:0] IDX_LINK_IE = 8'h26;
  localparam logic [7:0] IDX_STATUS = 8'h28;
  localparam logic [7:0] IDX_CMD = 8'h30;
  localparam logic [7:0] IDX_MASK [2] = '{8'h32, 8'h40};
  localparam logic [7:0] IDX_CRC [2] = '{8'h36, 8'h44};
  localparam logic [7:0] IDX_OFS [2] = '{8'h38, 8'h46};
  localparam logic [7:0] IDX_LAST [2] = '{8'h3A, 8'h48};
  localparam logic [7:0] IDX_WAKE_EN = 8'h50;
  // status bits
  localparam int ST_P_CHG = 0;
  localparam int ST_P_UP = 1;
  localparam int ST_S_CHG = 2;
  localparam int ST_S_UP = 3;
  localparam int ST_MAGIC = 4;
  localparam int ST_PIN = 5;
  localparam int ST_PAT = 6;
  // command bits
  localparam int CMD_EN0 = 0;
  localparam int CMD_UNI0 = 1;
  localparam int CMD_EN1 = 2;
  localparam int CMD_UNI1 = 3;
  localparam int CMD_CASC = 4;
  // enable bits (same layout as status)
  localparam int IE_PRI = 0;
  localparam int IE_SEC = 2;
  localparam int PHY_SEL_BIT = 0;
  localparam logic PHY_SEL_RST = 1'b1;
  localparam logic [7:0] BYTE_RST = 8'h00;
  localparam logic [15:0] CRC_RST = 16'h0000;
  localparam logic [31:0] MASK_RST = 32'h0000_0000;
  localparam logic [15:0] CRC_POLY_REFL = 16'hA001;
  localparam int MASK_SPAN = 32;
  localparam int DA_BYTES = 6;
  // poll period
  localparam int POLL_MS = 200;
  localparam int CLK_KHZ = 100000;
  localparam int POLL_CYCLES = POLL_MS * CLK_KHZ;
endpackage : wfl_pkg

// ==== core/wfl_wake_link.sv ====
// wakeup status, link-change polling and two wake-frame filters with AHB-Lite registers
// assumes rx bytes, sof and eof come from the MAC on core_clk; link pins are asynchronous
// What this block does
// - sample both PHY link states every 200 ms and compare with previous sample
// - a link change with its enable set raises the link interrupt line
// - link-enable bit 2 enables the secondary PHY interrupt, default off
// - status bits 0 and 2 set on link change, cleared by status read
// - status bits 1 and 3 show primary and secondary link-up state
// - status bit 4 sets on magic packet wake, cleared by status read
// - status bit 5 sets on external pin wake, cleared by status read
// - status bit 6 sets on wake-frame match, cleared by status read
// - command bits 0 and 2 enable filter zero and filter one
// - unicast bits 1 and 3 demand destination equals station address
// - command bit 4 cascades filters using filter one crc and last byte
// - cascaded filter one starts at byte offset0*2+32+offset1*2+1
// - each filter has a 32-bit byte mask, bit i selects start byte plus i
// - crc-16 x16+x15+x2+1 over masked bytes compared to stored value
// - offsets count two-byte units from the first destination byte
// - last masked byte must equal pattern byte as well as crc
// - phy control bit 0 selects embedded PHY, default one
// - every enabled wake event raises the wake interrupt line
`timescale 1ns/100ps
`default_nettype none
module wfl_wake_link #(
  parameter int POLL_CYCLES = wfl_pkg::POLL_CYCLES
) (
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  input wire logic primary_link_pin,
  input wire logic secondary_link_pin,
  input wire logic external_wake_pin,
  input wire logic magic_packet_seen,
  input wire logic rx_valid,
  input wire logic rx_sof,
  input wire logic [7:0] rx_byte,
  input wire logic rx_eof,
  input wire logic [47:0] station_address,
  output logic link_irq,
  output logic wake_irq,
  output logic phy_select
);
  localparam int PW = $clog2(POLL_CYCLES);
  localparam logic [11:0] POS_MAX = 12'hFFF;

  function automatic logic [15:0] crc16_byte(input logic [15:0] c, input logic [7:0] b);
    logic [15:0] r;
    r = c ^ {8'h00, b};
    for (int i = 0; i < 8; i++) begin
      r = r[0] ? ((r >> 1) ^ wfl_pkg::CRC_POLY_REFL) : (r >> 1);
    end
    return r;
  endfunction : crc16_byte

  function automatic logic mask_hit(input logic [31:0] m, input logic [11:0] s,
                                    input logic [11:0] p);
    logic [11:0] d;
    d = p - s;
    return (p >= s) && (d < 12'(wfl_pkg::MASK_SPAN)) && m[d[4:0]];
  endfunction : mask_hit

  // bus: zero wait states, read data captured at the address phase
  logic acc, rd_stat;
  logic wr_pend_q;
  logic [7:0] wr_idx_q;
  logic [31:0] rdata;
  logic [7:0] cmd_q, lie_q, wen_q, status_q;
  logic phy_sel_q;
  logic [31:0] mask_q [2];
  logic [15:0] crc_q [2];
  logic [7:0] ofs_q [2];
  logic [7:0] last_q [2];
  assign acc = hsel & htrans[1] & hready;
  assign rd_stat = acc & ~hwrite & (haddr[9:2] == wfl_pkg::IDX_STATUS) & ~|haddr[31:10];

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      wr_pend_q <= 1'b0;
      wr_idx_q <= 8'h00;
    end else begin
      wr_pend_q <= acc & hwrite & ~|haddr[31:10];
      wr_idx_q <= haddr[9:2];
    end
  end

  always_comb begin
    rdata = 32'h0000_0000;
    case (haddr[9:2])
      wfl_pkg::IDX_PHY_CTRL: rdata[0] = phy_sel_q;
      wfl_pkg::IDX_LINK_IE: rdata[7:0] = lie_q;
      wfl_pkg::IDX_STATUS: rdata[7:0] = status_q;
      wfl_pkg::IDX_CMD: rdata[7:0] = cmd_q;
      wfl_pkg::IDX_WAKE_EN: rdata[7:0] = wen_q;
      wfl_pkg::IDX_MASK[0]: rdata = mask_q[0];
      wfl_pkg::IDX_MASK[1]: rdata = mask_q[1];
      wfl_pkg::IDX_CRC[0]: rdata[15:0] = crc_q[0];
      wfl_pkg::IDX_CRC[1]: rdata[15:0] = crc_q[1];
      wfl_pkg::IDX_OFS[0]: rdata[7:0] = ofs_q[0];
      wfl_pkg::IDX_OFS[1]: rdata[7:0] = ofs_q[1];
      wfl_pkg::IDX_LAST[0]: rdata[7:0] = last_q[0];
      wfl_pkg::IDX_LAST[1]: rdata[7:0] = last_q[1];
      default: rdata = 32'h0000_0000;
    endcase
    if (|haddr[31:10]) begin
      rdata = 32'h0000_0000;
    end
  end

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      hrdata <= 32'h0000_0000;
      hreadyout <= 1'b1;
      hresp <= 1'b0;
    end else begin
      hreadyout <= 1'b1;
      hresp <= 1'b0;
      if (acc && !hwrite) begin
        hrdata <= rdata;
      end
    end
  end

  // control registers; reserved bits stay zero
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      cmd_q <= wfl_pkg::BYTE_RST;
      lie_q <= wfl_pkg::BYTE_RST;
      wen_q <= wfl_pkg::BYTE_RST;
      phy_sel_q <= wfl_pkg::PHY_SEL_RST;
    end else if (wr_pend_q) begin
      case (wr_idx_q)
        wfl_pkg::IDX_CMD: cmd_q <= {3'b000, hwdata[4:0]};
        wfl_pkg::IDX_LINK_IE: lie_q <= {5'b00000, hwdata[2], 1'b0, hwdata[0]};
        wfl_pkg::IDX_WAKE_EN: wen_q <= {1'b0, hwdata[6:4], 1'b0, hwdata[2], 1'b0, hwdata[0]};
        wfl_pkg::IDX_PHY_CTRL: phy_sel_q <= hwdata[wfl_pkg::PHY_SEL_BIT];
        default: cmd_q <= cmd_q;
      endcase
    end
  end

  // link polling
  logic [1:0] lnk_s1_q, lnk_s2_q, link_q, link_chg;
  logic [PW-1:0] poll_q;
  logic poll_tick;
  assign poll_tick = (poll_q == PW'(POLL_CYCLES - 1));
  assign link_chg = poll_tick ? (lnk_s2_q ^ link_q) : 2'b00;

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      lnk_s1_q <= 2'b00;
      lnk_s2_q <= 2'b00;
      poll_q <= '0;
      link_q <= 2'b00;
    end else begin
      lnk_s1_q <= {secondary_link_pin, primary_link_pin};
      lnk_s2_q <= lnk_s1_q;
      poll_q <= poll_tick ? '0 : poll_q + 1'b1;
      if (poll_tick) begin
        link_q <= lnk_s2_q;
      end
    end
  end

  // external pin: synchronise, wake on rising edge
  logic [2:0] pin_q;
  logic pin_rise;
  assign pin_rise = pin_q[1] & ~pin_q[2];
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      pin_q <= 3'b000;
    end else begin
      pin_q <= {pin_q[1:0], external_wake_pin};
    end
  end

  // frame position, first destination byte is position 1
  logic [11:0] pos_q, pos;
  logic da_ok_q, da_base;
  logic [7:0] sa_byte;
  assign pos = rx_sof ? 12'd1 : ((pos_q == POS_MAX) ? POS_MAX : pos_q + 12'd1);
  assign da_base = rx_sof ? 1'b1 : da_ok_q;
  assign sa_byte = station_address[8 * (wfl_pkg::DA_BYTES - int'(pos[2:0])) +: 8];
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      pos_q <= 12'd0;
      da_ok_q <= 1'b0;
    end else if (rx_valid) begin
      pos_q <= pos;
      if (pos <= 12'(wfl_pkg::DA_BYTES) && rx_byte != sa_byte) begin
        da_ok_q <= 1'b0;
      end else begin
        da_ok_q <= da_base;
      end
    end
  end

  logic casc;
  logic [11:0] start [2];
  logic [1:0] hit, match;
  assign casc = cmd_q[wfl_pkg::CMD_CASC];
  assign start[0] = {3'b000, ofs_q[0], 1'b0} + 12'd1;
  assign start[1] = casc ? start[0] + 12'(wfl_pkg::MASK_SPAN) + {3'b000, ofs_q[1], 1'b0}
                  : {3'b000, ofs_q[1], 1'b0} + 12'd1;

  for (genvar k = 0; k < 2; k++) begin : g_filt
    logic [15:0] acc_q, acc_b;
    logic [7:0] lbv_q;
    logic take, uni;
    assign acc_b = rx_sof ? 16'h0000 : acc_q;
    assign hit[k] = mask_hit(mask_q[k], start[k], pos);
    // cascaded, filter one's crc covers filter zero's span too
    assign take = hit[k] | ((k == 1) & casc & hit[0]);
    assign uni = cmd_q[2 * k + 1] | ((k == 1) & casc & cmd_q[wfl_pkg::CMD_UNI0]);
    assign match[k] = cmd_q[2 * k] & ((k == 1) | ~casc)
                    & ((k == 0) | ~casc | cmd_q[wfl_pkg::CMD_EN0])
                    & (acc_q == crc_q[k]) & (lbv_q == last_q[k])
                    & (~uni | da_ok_q);
    always_ff @(posedge core_clk) begin
      if (!rst_n) begin
        acc_q <= 16'h0000;
        lbv_q <= 8'h00;
      end else if (rx_valid) begin
        acc_q <= take ? crc16_byte(acc_b, rx_byte) : acc_b;
        lbv_q <= take ? rx_byte : (rx_sof ? 8'h00 : lbv_q);
      end
    end
    always_ff @(posedge core_clk) begin
      if (!rst_n) begin
        mask_q[k] <= wfl_pkg::MASK_RST;
        crc_q[k] <= wfl_pkg::CRC_RST;
        ofs_q[k] <= wfl_pkg::BYTE_RST;
        last_q[k] <= wfl_pkg::BYTE_RST;
      end else if (wr_pend_q) begin
        if (wr_idx_q == wfl_pkg::IDX_MASK[k]) mask_q[k] <= hwdata;
        if (wr_idx_q == wfl_pkg::IDX_CRC[k]) crc_q[k] <= hwdata[15:0];
        if (wr_idx_q == wfl_pkg::IDX_OFS[k]) ofs_q[k] <= hwdata[7:0];
        if (wr_idx_q == wfl_pkg::IDX_LAST[k]) last_q[k] <= hwdata[7:0];
      end
    end
  end

  // status flags: the set term wins over a read clear
  logic [7:0] set_ev;
  logic pat_ev;
  assign pat_ev = rx_eof & (|match);
  always_comb begin
    set_ev = 8'h00;
    set_ev[wfl_pkg::ST_P_CHG] = link_chg[0];
    set_ev[wfl_pkg::ST_S_CHG] = link_chg[1];
    set_ev[wfl_pkg::ST_MAGIC] = magic_packet_seen & wen_q[wfl_pkg::ST_MAGIC];
    set_ev[wfl_pkg::ST_PIN] = pin_rise & wen_q[wfl_pkg::ST_PIN];
    set_ev[wfl_pkg::ST_PAT] = pat_ev & wen_q[wfl_pkg::ST_PAT];
  end

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      status_q <= 8'h00;
    end else begin
      status_q <= (rd_stat ? 8'h00 : (status_q & 8'h75)) | set_ev;
      status_q[wfl_pkg::ST_P_UP] <= link_q[0];
      status_q[wfl_pkg::ST_S_UP] <= link_q[1];
    end
  end

  // link-up wake needs the level of the change flag and the new state
  logic lu_wake;
  assign lu_wake = (status_q[wfl_pkg::ST_P_CHG] & link_q[0] & wen_q[wfl_pkg::IE_PRI])
                 | (status_q[wfl_pkg::ST_S_CHG] & link_q[1] & wen_q[wfl_pkg::IE_SEC]);
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      link_irq <= 1'b0;
      wake_irq <= 1'b0;
      phy_select <= wfl_pkg::PHY_SEL_RST;
    end else begin
      link_irq <= (status_q[wfl_pkg::ST_P_CHG] & lie_q[wfl_pkg::IE_PRI])
                | (status_q[wfl_pkg::ST_S_CHG] & lie_q[wfl_pkg::IE_SEC]);
      wake_irq <= |status_q[6:4] | lu_wake;
      phy_select <= phy_sel_q;
    end
  end

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_n);

  a_poll_period: assert property (int'(poll_q) < POLL_CYCLES)
    else $error("poll counter out of range");
  a_link_irq: assert property ($rose(status_q[0]) && lie_q[0] |=> link_irq)
    else $error("link change did not raise link irq");
  a_sec_irq_off: assert property (!lie_q[2] && !(status_q[0] && lie_q[0]) |=> !link_irq)
    else $error("link irq without enable");
  a_link_flag: assert property (link_chg[1] |=> status_q[2])
    else $error("secondary change flag not set");
  a_read_clear: assert property (rd_stat && set_ev == 8'h00 |=> status_q[6:4] == 3'b000)
    else $error("status read did not clear flags");
  a_up_state: assert property (status_q[1] == $past(link_q[0]))
    else $error("primary up bit wrong");
  a_magic_flag: assert property (magic_packet_seen && wen_q[4] |=> status_q[4] ##1 wake_irq)
    else $error("magic wake not reported");
  a_pin_flag: assert property (pin_rise && wen_q[5] |=> status_q[5])
    else $error("pin wake not reported");
  a_pat_flag: assert property (pat_ev && wen_q[6] && rd_stat |=> status_q[6])
    else $error("pattern event lost on read");
  a_phy_sel: assert property (wr_pend_q && wr_idx_q == wfl_pkg::IDX_PHY_CTRL
                              |=> ##1 phy_select == $past(hwdata[0], 2))
    else $error("phy select not updated");
endmodule : wfl_wake_link
`default_nettype wire

// ==== dv/wfl_far_model.sv ====
// far-side model: MAC receive byte stream, magic detector and PHY link monitors
// assumes it shares core_clk with the block and changes lines just after rising edges
`timescale 1ns/100ps
`default_nettype none
module wfl_far_model (
  input wire logic core_clk,
  output logic primary_link_pin,
  output logic secondary_link_pin,
  output logic external_wake_pin,
  output logic magic_packet_seen,
  output logic rx_valid,
  output logic rx_sof,
  output logic [7:0] rx_byte,
  output logic rx_eof
);
  initial begin
    {primary_link_pin, secondary_link_pin, external_wake_pin} = 3'h0;
    {magic_packet_seen, rx_valid, rx_sof, rx_eof} = 4'h0;
    rx_byte = 8'hA5;
  end
  task automatic link(input logic p, input logic s);
    @(posedge core_clk);
    primary_link_pin <= p;
    secondary_link_pin <= s;
  endtask : link
  task automatic pin(input logic v);
    @(posedge core_clk);
    external_wake_pin <= v;
  endtask : pin
  task automatic magic();
    @(posedge core_clk);
    magic_packet_seen <= 1'b1;
    @(posedge core_clk);
    magic_packet_seen <= 1'b0;
  endtask : magic
  // eof follows the last byte by one idle cycle; the byte lane is scrambled once released
  task automatic send(input int n, input logic [7:0] fr [64]);
    for (int i = 0; i < n; i++) begin
      @(posedge core_clk);
      rx_valid <= 1'b1;
      rx_sof <= (i == 0);
      rx_byte <= fr[i];
    end
    @(posedge core_clk);
    {rx_valid, rx_sof, rx_eof} <= 3'b001;
    rx_byte <= ~fr[n-1];
    @(posedge core_clk);
    rx_eof <= 1'b0;
    rx_byte <= fr[n-1] ^ 8'h5A;
  endtask : send
endmodule : wfl_far_model
`default_nettype wire

// ==== dv/wfl_wake_link_tb_top.sv ====
// self-checking bench: AHB-Lite register tasks, link polling, wake sources, frame filters
// assumes the far-side model drives link pins, wake pin and the receive stream
`timescale 1ns/100ps
`default_nettype none
module wfl_wake_link_tb_top;
  logic core_clk = 1'b0, rst_n = 1'b0, hsel = 1'b0, hwrite = 1'b0;
  logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, rd;
  logic [1:0] htrans = 2'h0;
  logic [47:0] station_address = 48'h123456789ABC;
  logic [7:0] fr [64];
  wire logic hreadyout, hresp, link_irq, wake_irq, phy_select, p_l, s_l, e_w, m_p, rv, rs, re;
  wire logic [7:0] rb;
  int n_errors = 0, n_checks = 0, cyc = 0;
  wfl_far_model fm (.core_clk(core_clk), .primary_link_pin(p_l), .secondary_link_pin(s_l),
    .external_wake_pin(e_w), .magic_packet_seen(m_p), .rx_valid(rv), .rx_sof(rs),
    .rx_byte(rb), .rx_eof(re));
  wfl_wake_link #(.POLL_CYCLES(50)) uut (.core_clk(core_clk), .rst_n(rst_n), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata),
    .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
    .primary_link_pin(p_l), .secondary_link_pin(s_l), .external_wake_pin(e_w),
    .magic_packet_seen(m_p), .rx_valid(rv), .rx_sof(rs), .rx_byte(rb), .rx_eof(re),
    .station_address(station_address), .link_irq(link_irq), .wake_irq(wake_irq),
    .phy_select(phy_select));
  initial forever #5 core_clk = ~core_clk;
  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    n_checks++;
    if (got !== exp) begin
      $display("BAD %s expected %h seen %h", nm, exp, got);
      n_errors++;
    end
  endtask : chk
  // one single word transfer; the master waits on hready in both phases
  task automatic bus(input logic w, input logic [7:0] idx, input logic [31:0] wd);
    @(posedge core_clk);
    {hsel, htrans, hwrite} <= {1'b1, 2'h2, w};
    haddr <= {22'h0, idx, 2'h0};
    do @(posedge core_clk); while (hreadyout !== 1'b1);
    {hsel, htrans} <= 3'h0;
    hwdata <= wd;
    do @(posedge core_clk); while (hreadyout !== 1'b1);
    rd = hrdata;
  endtask : bus
  task automatic rchk(input string nm, input logic [7:0] idx, input logic [31:0] m,
    input logic [31:0] exp);
    bus(1'b0, idx, 32'h0);
    chk(nm, exp, rd & m);
  endtask : rchk
  task automatic wait_irq(input bit wk, input string nm);
    for (int k = 0; k < 130 && (wk ? wake_irq : link_irq) !== 1'b1; k++) @(posedge core_clk);
    chk(nm, 32'h1, {31'h0, wk ? wake_irq : link_irq});
  endtask : wait_irq
  // reference crc: reflected polynomial, zero start, masked bytes in frame order, lsb first
  function automatic logic [15:0] crc_ref(input logic [63:0] m);
    logic [15:0] c;
    logic fb;
    c = 16'h0000;
    for (int i = 0; i < 64; i++) begin
      if (m[i]) begin
        for (int j = 0; j < 8; j++) begin
          fb = c[0] ^ fr[i][j];
          c = c >> 1;
          if (fb) c = c ^ wfl_pkg::CRC_POLY_REFL;
        end
      end
    end
    return c;
  endfunction : crc_ref
  task automatic t_regs();
    rchk("phy_sel", wfl_pkg::IDX_PHY_CTRL, 32'h1, 32'h1);
    chk("phy_pin", 32'h1, {31'h0, phy_select});
    bus(1'b1, wfl_pkg::IDX_PHY_CTRL, 32'h0);
    rchk("phy_sel0", wfl_pkg::IDX_PHY_CTRL, 32'h1, 32'h0);
    chk("phy_pin0", 32'h0, {31'h0, phy_select});
    chk("hresp", 32'h0, {31'h0, hresp});
    rchk("status", wfl_pkg::IDX_STATUS, 32'hFF, 32'h0);
    rchk("cmd", wfl_pkg::IDX_CMD, 32'hFF, 32'h0);
    rchk("mask0", wfl_pkg::IDX_MASK[0], 32'hFFFFFFFF, 32'h0);
    rchk("unmapped", 8'hFF, 32'hFFFFFFFF, 32'h0);
    $display("regs done");
  endtask : t_regs
  task automatic t_link();
    bus(1'b1, wfl_pkg::IDX_LINK_IE, 32'h1);
    fm.link(1'b1, 1'b0);
    wait_irq(1'b0, "link_up_irq");
    rchk("st_up", wfl_pkg::IDX_STATUS, 32'h0F, 32'h03);
    rchk("st_clr", wfl_pkg::IDX_STATUS, 32'h0F, 32'h02);
    chk("irq_drop", 32'h0, {31'h0, link_irq});
    fm.link(1'b1, 1'b1);
    repeat (130) @(posedge core_clk);
    chk("sec_masked", 32'h0, {31'h0, link_irq});
    rchk("st_sec", wfl_pkg::IDX_STATUS, 32'h0F, 32'h0E);
    bus(1'b1, wfl_pkg::IDX_LINK_IE, 32'h5);
    fm.link(1'b1, 1'b0);
    wait_irq(1'b0, "sec_down_irq");
    rchk("st_down", wfl_pkg::IDX_STATUS, 32'h0F, 32'h06);
    // primary link-up wake: a down change must not wake, the following up change must
    bus(1'b1, wfl_pkg::IDX_WAKE_EN, 32'h1);
    fm.link(1'b0, 1'b0);
    wait_irq(1'b0, "pri_down_irq");
    chk("down_no_wake", 32'h0, {31'h0, wake_irq});
    rchk("st_pdown", wfl_pkg::IDX_STATUS, 32'h0F, 32'h01);
    fm.link(1'b1, 1'b0);
    wait_irq(1'b1, "link_up_wake");
    rchk("st_pup", wfl_pkg::IDX_STATUS, 32'h0F, 32'h03);
    $display("link done");
  endtask : t_link
  task automatic t_wake();
    bus(1'b1, wfl_pkg::IDX_WAKE_EN, 32'h30);
    fm.magic();
    wait_irq(1'b1, "magic_irq");
    rchk("st_magic", wfl_pkg::IDX_STATUS, 32'h70, 32'h10);
    fm.pin(1'b1);
    wait_irq(1'b1, "pin_irq");
    rchk("st_pin", wfl_pkg::IDX_STATUS, 32'h70, 32'h20);
    fm.pin(1'b0);
    // magic pulse lands on the same edge as the status read
    fork
      fm.magic();
      rchk("st_race", wfl_pkg::IDX_STATUS, 32'h70, 32'h0);
    join
    rchk("st_kept", wfl_pkg::IDX_STATUS, 32'h70, 32'h10);
    $display("wake done");
  endtask : t_wake
  task automatic frame(input logic [7:0] lt, input string nm, input logic [31:0] exp);
    fr[13] = lt;
    fm.send(40, fr);
    repeat (4) @(posedge core_clk);
    rchk(nm, wfl_pkg::IDX_STATUS, 32'h40, exp);
  endtask : frame
  task automatic t_filter();
    logic [31:0] en;
    for (int i = 0; i < 64; i++) fr[i] = 8'h00;
    {fr[0], fr[1], fr[2], fr[3], fr[4], fr[5], fr[12]} = 56'h123456789ABC08;
    bus(1'b1, wfl_pkg::IDX_WAKE_EN, 32'h40);
    for (int f = 0; f < 2; f++) begin
      en = 32'h1 << (2 * f);
      bus(1'b1, wfl_pkg::IDX_MASK[f], 32'h0000303F);
      bus(1'b1, wfl_pkg::IDX_CRC[f], {16'h0, crc_ref(64'h303F)});
      bus(1'b1, wfl_pkg::IDX_OFS[f], 32'h0);
      bus(1'b1, wfl_pkg::IDX_LAST[f], 32'h0);
      bus(1'b1, wfl_pkg::IDX_CMD, en);
      frame(8'h00, "match", 32'h40);
      frame(8'h01, "crc_bad", 32'h0);
      bus(1'b1, wfl_pkg::IDX_LAST[f], 32'h1);
      frame(8'h00, "last_bad", 32'h0);
      bus(1'b1, wfl_pkg::IDX_LAST[f], 32'h0);
      station_address <= 48'h123456789ABD;
      bus(1'b1, wfl_pkg::IDX_CMD, en | (en << 1));
      frame(8'h00, "uni_miss", 32'h0);
      station_address <= 48'h123456789ABC;
      frame(8'h00, "uni_hit", 32'h40);
      bus(1'b1, wfl_pkg::IDX_CMD, 32'h0);
      frame(8'h00, "disabled", 32'h0);
    end
    // cascade: filter one's span starts past filter zero's 32 bytes plus its own offset
    fr[34] = 8'h08;
    bus(1'b1, wfl_pkg::IDX_MASK[0], 32'h0000003F);
    bus(1'b1, wfl_pkg::IDX_MASK[1], 32'h00000003);
    bus(1'b1, wfl_pkg::IDX_OFS[1], 32'h1);
    bus(1'b1, wfl_pkg::IDX_CRC[1], {16'h0, crc_ref(64'h0000000C_0000003F)});
    bus(1'b1, wfl_pkg::IDX_CRC[0], {16'h0, ~crc_ref(64'h0000000C_0000003F)});
    bus(1'b1, wfl_pkg::IDX_CMD, 32'h15);
    fork
      fm.send(40, fr);
      begin
        repeat (40) @(posedge core_clk);
        rchk("casc_race", wfl_pkg::IDX_STATUS, 32'h40, 32'h0);
      end
    join
    repeat (4) @(posedge core_clk);
    rchk("casc_match", wfl_pkg::IDX_STATUS, 32'h40, 32'h40);
    bus(1'b1, wfl_pkg::IDX_OFS[1], 32'h0);
    frame(8'h00, "casc_shift", 32'h0);
    $display("filter done");
  endtask : t_filter
  task automatic give_verdict();
    $display("checks %0d mismatches %0d", n_checks, n_errors);
    if (n_errors == 0 && n_checks > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : give_verdict
  // ceiling well above the thousand or so cycles the scenarios need
  always @(posedge core_clk) begin
    cyc++;
    if (cyc == 20000) begin
      n_errors++;
      give_verdict();
    end
  end
  initial begin
    repeat (4) @(posedge core_clk);
    rst_n <= 1'b1;
    @(posedge core_clk);
    t_regs();
    t_link();
    t_wake();
    t_filter();
    give_verdict();
  end
endmodule : wfl_wake_link_tb_top
`default_nettype wire
